// ### pcl_loader.sv
// Function
// R1 - port 2 word read from address 64h, port 3 from 66h.
// R2 - port 4 word read from address 68h, port 5 from 6Ah.
// R3 - word bit 0 goes to C0h bit 24, slot implemented.
// R4 - word bit 1 goes to D0h bit 28, connector reference clock.
// R5 - word bit 2 goes to 40h bit 21, device init required.
// R6 - word bit 3 goes to 144h bit 4, VC1 is low priority.
// R7 - word bits 6:4 go to CCh bits 26:24, logical port number.
// R8 - word bits 15:9 go to 154h bits 7:1, VC0 map.
// R9 - load all words once after reset; loaded values replace defaults.
`timescale 1ns/1ns
`default_nettype none

module pcl_loader (
   input  wire logic                        clk,
   input  wire logic                        sys_rst,
   output logic                             rd_req,
   output logic [7:0]                       rd_addr,
   input  wire logic                        rd_valid,
   input  wire logic [15:0]                 rd_data,
   output logic                             load_done,
   output pcl_pkg::pcl_fields_t [3:0]       port_fields,
   output pcl_pkg::pcl_regs_t   [3:0]       port_regs
);

   typedef enum logic [1:0] {PCL_IDLE, PCL_READ, PCL_DONE} pcl_state_t;

   pcl_state_t  state_q;
   logic [1:0]  idx_q;
   logic [15:0] word_q [4];
   logic        done_q;
   logic        take;
   logic        last_idx;

   function automatic logic [7:0] port_addr(input logic [1:0] idx);
      case (idx)
         // R1 ports 2 and 3
         2'd0:    port_addr = pcl_pkg::ADDR_PORT2;
         2'd1:    port_addr = pcl_pkg::ADDR_PORT3;
         // R2 ports 4 and 5
         2'd2:    port_addr = pcl_pkg::ADDR_PORT4;
         default: port_addr = pcl_pkg::ADDR_PORT5;
      endcase
   endfunction

   // a word is taken only while a read is outstanding
   assign take     = (state_q == PCL_READ) && rd_valid;
   assign last_idx = (idx_q == 2'(pcl_pkg::NUM_PORTS - 1));

   // R9 single load sequence
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= PCL_IDLE;
      end else begin
         case (state_q)
            PCL_IDLE: begin
               state_q <= PCL_READ;
            end
            PCL_READ: begin
               if (rd_valid && last_idx) begin
                  state_q <= PCL_DONE;
               end
            end
            PCL_DONE: begin
               state_q <= PCL_DONE;
            end
            default: begin
               state_q <= PCL_IDLE;
            end
         endcase
      end
   end

   // R1 R2 port index advance
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         idx_q <= 2'd0;
      end else if (take && !last_idx) begin
         idx_q <= idx_q + 2'd1;
      end
   end

   // R9 done flag sticks
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         done_q <= 1'b0;
      end else if (take && last_idx) begin
         done_q <= 1'b1;
      end
   end

   // R9 loaded word replaces default
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < pcl_pkg::NUM_PORTS; i++) begin
            word_q[i] <= pcl_pkg::DEFAULT_WORD;
         end
      end else if (take) begin
         word_q[idx_q] <= rd_data;
      end
   end

   assign rd_req    = (state_q == PCL_READ);
   assign rd_addr   = port_addr(idx_q);
   assign load_done = done_q;

   for (genvar g = 0; g < pcl_pkg::NUM_PORTS; g++) begin : g_port
      pcl_field_map u_map (
         .word   (word_q[g]),
         .fields (port_fields[g]),
         .regs   (port_regs[g])
      );
   end

endmodule

`default_nettype wire

// ### pcl_pkg.sv
`default_nettype none
package pcl_pkg;

   localparam int          NUM_PORTS     = 4;
   localparam int          FIRST_PORT    = 2;
   localparam int          WORD_W        = 16;
   localparam int          ADDR_W        = 8;

   // word address of the setup word for each downstream port
   localparam logic [7:0]  ADDR_PORT2    = 8'h64;
   localparam logic [7:0]  ADDR_PORT3    = 8'h66;
   localparam logic [7:0]  ADDR_PORT4    = 8'h68;
   localparam logic [7:0]  ADDR_PORT5    = 8'h6a;

   // target configuration offsets
   localparam logic [11:0] OFS_SLOT_CAP  = 12'h0c0;
   localparam logic [11:0] OFS_SLOT_CLK  = 12'h0d0;
   localparam logic [11:0] OFS_DSI       = 12'h040;
   localparam logic [11:0] OFS_LPVC      = 12'h144;
   localparam logic [11:0] OFS_PORT_NUM  = 12'h0cc;
   localparam logic [11:0] OFS_VC0_MAP   = 12'h154;

   // source bit positions in the setup word
   localparam int          SRC_SLOT_IMPL = 0;
   localparam int          SRC_SLOT_CLK  = 1;
   localparam int          SRC_DSI       = 2;
   localparam int          SRC_LPVC      = 3;
   localparam int          SRC_PNUM_LO   = 4;
   localparam int          SRC_PNUM_HI   = 6;
   localparam int          SRC_MAP_LO    = 9;
   localparam int          SRC_MAP_HI    = 15;

   // destination bit positions in the 32-bit target registers
   localparam int          DST_SLOT_IMPL = 24;
   localparam int          DST_SLOT_CLK  = 28;
   localparam int          DST_DSI       = 21;
   localparam int          DST_LPVC      = 4;
   localparam int          DST_PNUM_LO   = 24;
   localparam int          DST_PNUM_HI   = 26;
   localparam int          DST_MAP_LO    = 1;
   localparam int          DST_MAP_HI    = 7;

   // field defaults before loading (all bits zero)
   localparam logic [15:0] DEFAULT_WORD  = 16'h0000;

   typedef struct packed {
      logic       slot_impl;
      logic       slot_clk;
      logic       dsi_req;
      logic       lpvc_vc1;
      logic [2:0] port_num;
      logic [6:0] vc0_map;
   } pcl_fields_t;

   typedef struct packed {
      logic [31:0] slot_cap;
      logic [31:0] slot_clk;
      logic [31:0] dsi;
      logic [31:0] lpvc;
      logic [31:0] port_num;
      logic [31:0] vc0_map;
   } pcl_regs_t;

endpackage
`default_nettype wire

// ### pcl_field_map.sv
`timescale 1ns/1ns
`default_nettype none

module pcl_field_map (
   input  wire logic [15:0]        word,
   output pcl_pkg::pcl_fields_t    fields,
   output pcl_pkg::pcl_regs_t      regs
);

   always_comb begin
      fields.slot_impl = word[pcl_pkg::SRC_SLOT_IMPL];
      fields.slot_clk  = word[pcl_pkg::SRC_SLOT_CLK];
      fields.dsi_req   = word[pcl_pkg::SRC_DSI];
      fields.lpvc_vc1  = word[pcl_pkg::SRC_LPVC];
      fields.port_num  = word[pcl_pkg::SRC_PNUM_HI:pcl_pkg::SRC_PNUM_LO];
      fields.vc0_map   = word[pcl_pkg::SRC_MAP_HI:pcl_pkg::SRC_MAP_LO];
   end

   always_comb begin
      regs = '0;
      // R3 slot implemented bit
      regs.slot_cap[pcl_pkg::DST_SLOT_IMPL] = fields.slot_impl;
      // R4 slot clock bit
      regs.slot_clk[pcl_pkg::DST_SLOT_CLK] = fields.slot_clk;
      // R5 dsi required bit
      regs.dsi[pcl_pkg::DST_DSI] = fields.dsi_req;
      // R6 lpvc count bit
      regs.lpvc[pcl_pkg::DST_LPVC] = fields.lpvc_vc1;
      // R7 logical port number
      regs.port_num[pcl_pkg::DST_PNUM_HI:pcl_pkg::DST_PNUM_LO] = fields.port_num;
      // R8 vc0 traffic class map
      regs.vc0_map[pcl_pkg::DST_MAP_HI:pcl_pkg::DST_MAP_LO] = fields.vc0_map;
   end

endmodule

`default_nettype wire

// ### pcl_store_model.sv
`timescale 1ns/1ns
`default_nettype none
module pcl_store_model (
   input wire logic        clk,
   input wire logic        rd_req,
   input wire logic [7:0]  rd_addr,
   input wire logic [63:0] mem,
   output logic            rd_valid = 1'b0,
   output logic [15:0]     rd_data = 16'h0
);
   logic [1:0] wt_q = 2'h0;
   // wait depends on the address; data toggles when not valid
   wire logic  go = rd_req && !rd_valid && wt_q == rd_addr[2:1];
   // stray pulses after loading, which the loader must refuse
   wire logic  stray = !rd_req && rd_addr == 8'h6a && !rd_valid;
   always @(posedge clk) begin
      rd_valid <= go || stray;
      rd_data <= go ? mem[(rd_addr - 8'h64) * 8 +: 16] : ~rd_data;
      wt_q <= rd_req && !go ? wt_q + 2'h1 : 2'h0;
   end
endmodule
`default_nettype wire

// ### pcl_loader_checker.sv
`timescale 1ns/1ns
`default_nettype none
module pcl_loader_checker (
   input wire logic                     clk,
   input wire logic                     sys_rst,
   input wire logic                     rd_req,
   input wire logic [7:0]               rd_addr,
   input wire logic                     rd_valid,
   input wire logic [15:0]              rd_data,
   input wire logic                     load_done,
   input wire pcl_pkg::pcl_regs_t [3:0] port_regs
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire logic t0 = rd_req && rd_valid && rd_addr == 8'h64;
   wire logic t3 = rd_req && rd_valid && rd_addr == 8'h6a;
   wire pcl_pkg::pcl_regs_t r = port_regs[0];
   a_addr_next: assert property(t0 |=> rd_addr == 8'h66) else $error("addr");
   a_slot_impl: assert property(t0 |=> r.slot_cap[24] == $past(rd_data[0])) else $error("slot");
   a_slot_clk: assert property(t0 |=> r.slot_clk[28] == $past(rd_data[1])) else $error("clk");
   a_dsi_req: assert property(t0 |=> r.dsi[21] == $past(rd_data[2])) else $error("dsi");
   a_lpvc_bit: assert property(t0 |=> r.lpvc[4] == $past(rd_data[3])) else $error("lpvc");
   a_port_num: assert property(t0 |=> r.port_num[26:24] == $past(rd_data[6:4])) else $error("pnum");
   a_vc0_map: assert property(t0 |=> r.vc0_map[7:1] == $past(rd_data[15:9])) else $error("map");
   a_load_once: assert property(t3 |=> (load_done && !rd_req) [*4]) else $error("done");
   a_hold_done: assert property(load_done && rd_valid |=> $stable(port_regs)) else $error("hold");
   c_take: cover property(t0);
   c_done: cover property($rose(load_done));
   c_wait: cover property((rd_req && !rd_valid) [*2]);
   c_refused: cover property(load_done && rd_valid);
endmodule
bind pcl_loader pcl_loader_checker chk_u (.*);
`default_nettype wire

// ### tb_port_config_word_loader.sv
`timescale 1ns/1ns
`default_nettype none
module tb_port_config_word_loader;
   logic        clk = 1'b0, sys_rst = 1'b1, rd_req, rd_valid, load_done;
   logic [7:0]  rd_addr;
   logic [15:0] rd_data;
   logic [63:0] mem = 64'h0;
   logic [17:0] q[$], n;
   logic [7:0]  seen_addr;
   pcl_pkg::pcl_fields_t [3:0] port_fields;
   pcl_pkg::pcl_regs_t   [3:0] port_regs;
   int          num_errors = 0, n_checks = 0;
   always #10 clk = ~clk;
   pcl_loader dut_u (.*);
   pcl_store_model st_u (.*);
   task automatic chk(input logic ok, input string s);
      n_checks++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("mismatch %0t %s", $time, s);
      end
   endtask
   task automatic conclude();
      $display("%0d checks, %0d mismatches", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk) if (rd_req && rd_valid) begin
      seen_addr = rd_addr;
      @(negedge clk);
      n = q.pop_front();
      chk(seen_addr === 8'h64 + {5'h0, n[17:16], 1'b0}, "addr");
      chk(port_regs[n[17:16]] ===
         {7'h0, n[0], 27'h0, n[1], 38'h0, n[2], 48'h0, n[3], 9'h0, n[6:4], 48'h0, n[15:9], 1'h0}, "word");
      chk(port_fields[n[17:16]] === {n[0], n[1], n[2], n[3], n[6:4], n[15:9]}, "fields");
   end
   initial begin
      void'($urandom(32'hcdf0c323));
      // run 1 is cut by a reset in mid-load
      for (int r = 0; r < 3; r++) begin
         @(posedge clk);
         sys_rst <= 1'b1;
         mem <= {$urandom, $urandom};
         repeat (3) @(posedge clk);
         @(negedge clk);
         q.delete();
         for (int k = 0; k < 4; k++) q.push_back({2'(k), mem[k*16 +: 16]});
         chk(port_regs === '0 && port_fields === '0 && rd_req === 1'b0 && load_done === 1'b0, "reset");
         chk(rd_addr === 8'h64, "reset addr");
         @(posedge clk);
         sys_rst <= 1'b0;
         for (int i = 0; i < ((r == 1) ? 6 : 50) && load_done !== 1'b1; i++) @(posedge clk);
         if (r != 1) begin
            repeat (4) @(negedge clk);
            chk(load_done === 1'b1 && rd_req === 1'b0 && q.size() == 0, "done");
            if (load_done !== 1'b1) break;
         end
         $display("test %0d ended", r);
      end
      conclude();
   end
endmodule
`default_nettype wire
